// ### verilog/pll_consts.svh
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// ----------------------------------------
// enhancement control bit positions
// ----------------------------------------
`define CTL_WIDTH        8
`define CTL_BIT_PWRDN    3
`define CTL_BIT_CLOAD    4
`define CTL_BIT_MODSEL   5
`define CTL_BIT_PRESC    6
`define CTL_BIT_CLKOFF   7
`define CTL_RESET        8'h00

// ----------------------------------------
// synchroniser vector layout
// ----------------------------------------
`define SYN_SCLK         0
`define SYN_SDATA        1
`define SYN_STROBE       2
`define SYN_SMODE        3
`define SYN_BMODE        4
`define SYN_CTL_EN_N     5
`define SYN_VCO          6
`define SYN_REF          7
`define SYN_MODSEL       8
`define SYN_PRESC        9
`define SYN_PDATA_LO     10
`define SYN_PDATA_HI     17
`define SYN_WIDTH        18
`define SYN_RESET        18'h00000

`endif

// ### verilog/pll_pkg.sv
`default_nettype none

package pll_pkg;

  // ----------------------------------------
  // phase detector states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_UP,
    PFD_DOWN
  } pfd_state_e;

  // ----------------------------------------
  // enhancement loader state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] shift;       // serial shift stage
    logic [7:0] hold;        // buffered control value
  } ctl_state_s;

  // ----------------------------------------
  // top-level state
  // ----------------------------------------
  typedef struct packed {
    logic [17:0] sync0;      // first synchroniser stage
    logic [17:0] sync1;      // second synchroniser stage
    logic [17:0] prev;       // delayed copy for edge detection
    pfd_state_e  pfd;        // phase detector state
    logic        up_n;       // pump-up pin
    logic        down_n;     // pump-down pin
    logic        lock;       // lock pin
    logic        diag;       // diagnostic data pin
    logic        vco_out;    // gated divided vco
    logic        ref_out;    // gated divided reference
    logic        pwrdn;      // power down status
    logic        cload;      // continuous counter load
  } top_state_s;

endpackage : pll_pkg

`default_nettype wire

// ### verilog/enh_loader.sv
`include "pll_consts.svh"
`default_nettype none

// ----------------------------------------
// enhancement register loader
// ----------------------------------------
module ctl_loader
(
  input  wire logic       ref_clk,      // system clock
  input  wire logic       rst,          // synchronous reset
  input  wire logic       sclk_rise,    // serial clock rising edge
  input  wire logic       sdata,        // serial data level
  input  wire logic       strobe,       // enhancement strobe level
  input  wire logic       strobe_rise,  // strobe rising edge
  input  wire logic       strobe_fall,  // strobe falling edge
  input  wire logic       serial_mode,  // high selects serial loading
  input  wire logic       direct_mode,  // high blocks all loading
  input  wire logic [7:0] par_data,     // parallel data bus
  output logic      [7:0] ctl_value     // buffered control bits
);

  pll_pkg::ctl_state_s st;       // registered state
  pll_pkg::ctl_state_s next_st;  // next state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    if (!direct_mode && serial_mode)
    begin
      // serial shift path
      // first bit in travels to bit 0
      if (strobe && sclk_rise)
        next_st.shift = {sdata, st.shift[7:1]};
      // capture on strobe falling edge so partial loads never act
      if (strobe_fall)
        next_st.hold = st.shift;
    end
    else if (!direct_mode && strobe_rise)
    begin
      // parallel bus is bit-reversed: bus bit 7 is control bit 0
      next_st.hold = {<<{par_data}};
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      // clear both stages so no stale bits reach the outputs
      st.shift <= `CTL_RESET;
      st.hold  <= `CTL_RESET;
    end
    else
      st <= next_st;
  end

  assign ctl_value = st.hold;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_serial_capture;
    @(posedge ref_clk) disable iff (rst)
      (serial_mode && !direct_mode && strobe_fall) |=> (ctl_value == $past(st.shift));
  endproperty
  a_serial_capture: assert property (p_serial_capture)
    else $error("serial enhancement value not captured on strobe fall");

endmodule : ctl_loader

`default_nettype wire

// ### verilog/pll_enhancement_and_phase_detect.sv
`include "pll_consts.svh"
`default_nettype none


module pll_enhancement_and_phase_detect
(
  input  wire logic       ref_clk,               // 100 MHz system clock
  input  wire logic       rst,                   // synchronous reset, active high
  input  wire logic       sclk,                  // serial clock pin
  input  wire logic       sdata,                 // serial data pin
  input  wire logic       ctl_strobe,            // enhancement write strobe pin
  input  wire logic       smode,                 // serial mode select pin
  input  wire logic       bmode,                 // direct mode select pin
  input  wire logic [7:0] par_data,              // parallel data pins
  input  wire logic       enhancement_enable_n,  // control bit enable, active low
  input  wire logic       divided_vco,           // divided vco signal
  input  wire logic       divided_ref,           // divided reference signal
  input  wire logic       modulus_select,        // prescaler modulus select
  input  wire logic       prescaler_raw,         // undivided prescaler output
  output logic            pump_up_pulse_n,       // pump-up pulse, active low
  output logic            pump_down_pulse_n,     // pump-down pulse, active low
  output logic            lock_indicator,        // high while no pump pulse
  output logic            diag_out,              // diagnostic data output
  output logic            divided_vco_out,       // gated divided vco
  output logic            divided_ref_out,       // gated divided reference
  output logic            power_down,            // power down status
  output logic            counter_load_cont      // continuous counter load
);

  // ----------------------------------------
  // state and decoded signals
  // ----------------------------------------
  pll_pkg::top_state_s st;          // registered state
  pll_pkg::top_state_s next_st;     // next state
  logic [17:0]         pins;        // raw pin vector
  logic [17:0]         rise;        // rising edges after sync
  logic [17:0]         fall;        // falling edges after sync
  logic [7:0]          ctl_value;   // buffered control value
  logic [7:0]          eff;         // control bits in force

  assign pins = {par_data, prescaler_raw, modulus_select, divided_ref, divided_vco,
                 enhancement_enable_n, bmode, smode, ctl_strobe, sdata, sclk};

  // ----------------------------------------
  // edge detection, one lane per pin
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SYN_WIDTH; g++)
    begin : g_edge
      assign rise[g] = st.sync1[g] & ~st.prev[g];
      assign fall[g] = ~st.sync1[g] & st.prev[g];
    end
  endgenerate

  // ----------------------------------------
  // enhancement register loader
  // ----------------------------------------
  ctl_loader u_loader
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .sclk_rise   (rise[`SYN_SCLK]),
    .sdata       (st.sync1[`SYN_SDATA]),
    .strobe      (st.sync1[`SYN_STROBE]),
    .strobe_rise (rise[`SYN_STROBE]),
    .strobe_fall (fall[`SYN_STROBE]),
    .serial_mode (st.sync1[`SYN_SMODE]),
    .direct_mode (st.sync1[`SYN_BMODE]),
    .par_data    (st.sync1[`SYN_PDATA_HI:`SYN_PDATA_LO]),
    .ctl_value   (ctl_value)
  );

  // ----------------------------------------
  // control bits in force
  // ----------------------------------------
  // enable pin gates all bits
  // a zero bit stays inactive
  // reserved bits are carried but steer nothing, so a host slip is harmless
  assign eff = st.sync1[`SYN_CTL_EN_N] ? `CTL_RESET : ctl_value;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.sync0 = pins;
    next_st.sync1 = st.sync0;
    next_st.prev  = st.sync1;
    next_st.pwrdn = eff[`CTL_BIT_PWRDN];
    next_st.cload = eff[`CTL_BIT_CLOAD];

    // phase detector, idle while powered down
    if (eff[`CTL_BIT_PWRDN])
    begin
      next_st.pfd = pll_pkg::PFD_IDLE;
    end
    else
    begin
      case (st.pfd)
        pll_pkg::PFD_IDLE:
        begin
          if (rise[`SYN_REF] && !rise[`SYN_VCO])
            next_st.pfd = pll_pkg::PFD_UP;
          else if (rise[`SYN_VCO] && !rise[`SYN_REF])
            next_st.pfd = pll_pkg::PFD_DOWN;
        end
        pll_pkg::PFD_UP:
        begin
          if (rise[`SYN_VCO])
            next_st.pfd = pll_pkg::PFD_IDLE;
        end
        pll_pkg::PFD_DOWN:
        begin
          if (rise[`SYN_REF])
            next_st.pfd = pll_pkg::PFD_IDLE;
        end
        default:
          next_st.pfd = pll_pkg::PFD_IDLE;
      endcase
    end

    next_st.up_n   = (next_st.pfd != pll_pkg::PFD_UP);
    next_st.down_n = (next_st.pfd != pll_pkg::PFD_DOWN);
    next_st.lock   = next_st.up_n & next_st.down_n;

    // diagnostic output; modulus select wins if both bits set
    if (eff[`CTL_BIT_PWRDN])
      next_st.diag = 1'b0;
    else if (eff[`CTL_BIT_MODSEL])
      next_st.diag = st.sync1[`SYN_MODSEL];
    else if (eff[`CTL_BIT_PRESC])
      next_st.diag = st.sync1[`SYN_PRESC];
    else
      next_st.diag = 1'b0;

    next_st.vco_out = st.sync1[`SYN_VCO] & ~eff[`CTL_BIT_CLKOFF] & ~eff[`CTL_BIT_PWRDN];
    next_st.ref_out = st.sync1[`SYN_REF] & ~eff[`CTL_BIT_CLKOFF] & ~eff[`CTL_BIT_PWRDN];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st         <= '0;
      st.pfd     <= pll_pkg::PFD_IDLE;
      st.up_n    <= 1'b1;
      st.down_n  <= 1'b1;
      st.lock    <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pump_up_pulse_n   = st.up_n;
  assign pump_down_pulse_n = st.down_n;
  assign lock_indicator    = st.lock;
  assign diag_out          = st.diag;
  assign divided_vco_out   = st.vco_out;
  assign divided_ref_out   = st.ref_out;
  assign power_down        = st.pwrdn;
  assign counter_load_cont = st.cload;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_enable_gate;
    @(posedge ref_clk) disable iff (rst)
      st.sync1[`SYN_CTL_EN_N] |=> (!power_down && !counter_load_cont && !diag_out);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("control bits acted while enable high");

  property p_zero_inactive;
    @(posedge ref_clk) disable iff (rst)
      (!st.sync1[`SYN_CTL_EN_N] && ctl_value == `CTL_RESET) |=> (!power_down && !diag_out);
  endproperty
  a_zero_inactive: assert property (p_zero_inactive)
    else $error("cleared control bits left a function active");

  property p_power_down;
    @(posedge ref_clk) disable iff (rst)
      eff[`CTL_BIT_PWRDN] |=> (power_down && pump_up_pulse_n && pump_down_pulse_n
                               && !divided_vco_out && !divided_ref_out);
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power down did not quiet the block");

  property p_cload;
    @(posedge ref_clk) disable iff (rst)
      counter_load_cont == $past(eff[`CTL_BIT_CLOAD]);
  endproperty
  a_cload: assert property (p_cload)
    else $error("continuous load flag does not follow its bit");

  property p_modsel;
    @(posedge ref_clk) disable iff (rst)
      (eff[`CTL_BIT_MODSEL] && !eff[`CTL_BIT_PWRDN])
        |=> (diag_out == $past(st.sync1[`SYN_MODSEL]));
  endproperty
  a_modsel: assert property (p_modsel)
    else $error("diagnostic output not carrying modulus select");

  property p_presc;
    @(posedge ref_clk) disable iff (rst)
      (eff[`CTL_BIT_PRESC] && !eff[`CTL_BIT_MODSEL] && !eff[`CTL_BIT_PWRDN])
        |=> (diag_out == $past(st.sync1[`SYN_PRESC]));
  endproperty
  a_presc: assert property (p_presc)
    else $error("diagnostic output not carrying raw prescaler");

  property p_clk_off;
    @(posedge ref_clk) disable iff (rst)
      eff[`CTL_BIT_CLKOFF] |=> (!divided_vco_out && !divided_ref_out);
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("divided clocks not disabled");

  property p_rise_only;
    @(posedge ref_clk) disable iff (rst)
      (st.pfd == pll_pkg::PFD_IDLE && !rise[`SYN_VCO] && !rise[`SYN_REF]) |=>
        (pump_up_pulse_n && pump_down_pulse_n);
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("pump pulse started without a rising edge");

  property p_vco_leads;
    @(posedge ref_clk) disable iff (rst)
      (st.pfd == pll_pkg::PFD_IDLE && rise[`SYN_VCO] && !rise[`SYN_REF] && !eff[`CTL_BIT_PWRDN])
        |=> (!pump_down_pulse_n && pump_up_pulse_n);
  endproperty
  a_vco_leads: assert property (p_vco_leads)
    else $error("vco lead did not pulse pump-down");

  property p_ref_leads;
    @(posedge ref_clk) disable iff (rst)
      (st.pfd == pll_pkg::PFD_IDLE && rise[`SYN_REF] && !rise[`SYN_VCO] && !eff[`CTL_BIT_PWRDN])
        |=> (!pump_up_pulse_n && pump_down_pulse_n);
  endproperty
  a_ref_leads: assert property (p_ref_leads)
    else $error("reference lead did not pulse pump-up");

  property p_width;
    @(posedge ref_clk) disable iff (rst)
      (!pump_up_pulse_n && !rise[`SYN_VCO] && !eff[`CTL_BIT_PWRDN]) |=> !pump_up_pulse_n;
  endproperty
  a_width: assert property (p_width)
    else $error("pump-up pulse ended before the lagging edge");

  property p_lock;
    @(posedge ref_clk) disable iff (rst)
      lock_indicator == (pump_up_pulse_n & pump_down_pulse_n);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock indicator differs from AND of pumps");

endmodule : pll_enhancement_and_phase_detect

`default_nettype wire

// ### sim/loop_filter_model.sv
`default_nettype none

// ----------------------------------------
// far side: loop filter integrating pump pulses, vco/ref edge source
// ----------------------------------------
module loop_filter_model
(
  input  wire logic ref_clk,            // system clock
  input  wire logic pump_up_pulse_n,    // pump-up from device
  input  wire logic pump_down_pulse_n,  // pump-down from device
  input  wire logic lock_indicator,     // lock from device
  output logic      divided_vco,        // divided vco to device
  output logic      divided_ref,        // divided reference to device
  output int        up_cnt,             // cycles of pump-up charge
  output int        dn_cnt,             // cycles of pump-down charge
  output int        lk_cnt              // cycles without lock
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // charge integration, sampled mid-cycle where outputs are settled
  // ----------------------------------------
  always @(negedge ref_clk)
  begin
    up_cnt += (pump_up_pulse_n === 1'b0) ? 1 : 0;
    dn_cnt += (pump_down_pulse_n === 1'b0) ? 1 : 0;
    lk_cnt += (lock_indicator !== 1'b1) ? 1 : 0;
  end

  // hold both divided lines at one level, simultaneous edges only
  task automatic set_lvl(input logic v);
    divided_vco = v;
    divided_ref = v;
  endtask : set_lvl

  // one compare period: first edge, offset cycles later the second;
  // falls are staggered so a detector acting on falls would show it
  task automatic pair(input bit ref_first, input int offset);
    up_cnt = 0;
    dn_cnt = 0;
    lk_cnt = 0;
    if (ref_first)
      divided_ref = 1'b1;
    else
      divided_vco = 1'b1;
    repeat (offset) @(negedge ref_clk);
    divided_ref = 1'b1;
    divided_vco = 1'b1;
    repeat (10) @(negedge ref_clk);
    divided_ref = 1'b0;
    repeat (5) @(negedge ref_clk);
    divided_vco = 1'b0;
    repeat (10) @(negedge ref_clk);
  endtask : pair

  initial
  begin
    set_lvl(1'b0);
    up_cnt = 0;
    dn_cnt = 0;
    lk_cnt = 0;
  end
endmodule : loop_filter_model

`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       sclk = 1'b0;
  logic       sdata = 1'b0;
  logic       ctl_strobe = 1'b0;
  logic       smode = 1'b0;
  logic       bmode = 1'b0;
  logic [7:0] par_data = 8'h00;
  logic       enable_n = 1'b0;         // control bits enabled
  logic       modulus_select = 1'b0;
  logic       prescaler_raw = 1'b0;
  logic       divided_vco;
  logic       divided_ref;
  logic       up_n, down_n, lock, diag, vco_out, ref_out, pwrdn, cload;
  int         up_cnt, dn_cnt, lk_cnt;
  int         mismatches = 0;
  int         n_tests = 0;

  // 100 MHz clock, free running for the whole run
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  pll_enhancement_and_phase_detect u_dut
  (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .sclk                 (sclk),
    .sdata                (sdata),
    .ctl_strobe           (ctl_strobe),
    .smode                (smode),
    .bmode                (bmode),
    .par_data             (par_data),
    .enhancement_enable_n (enable_n),
    .divided_vco          (divided_vco),
    .divided_ref          (divided_ref),
    .modulus_select       (modulus_select),
    .prescaler_raw        (prescaler_raw),
    .pump_up_pulse_n      (up_n),
    .pump_down_pulse_n    (down_n),
    .lock_indicator       (lock),
    .diag_out             (diag),
    .divided_vco_out      (vco_out),
    .divided_ref_out      (ref_out),
    .power_down           (pwrdn),
    .counter_load_cont    (cload)
  );

  loop_filter_model u_lf
  (
    .ref_clk           (ref_clk),
    .pump_up_pulse_n   (up_n),
    .pump_down_pulse_n (down_n),
    .lock_indicator    (lock),
    .divided_vco       (divided_vco),
    .divided_ref       (divided_ref),
    .up_cnt            (up_cnt),
    .dn_cnt            (dn_cnt),
    .lk_cnt            (lk_cnt)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // reserved bits zero: only bits 7..3 can be given
  // every pin level held 4 cycles, above the 3-cycle sampling need
  task automatic wr(input bit par, input logic [4:0] fn);
    logic [7:0] v;
    v = {fn, 3'b000};
    smode = ~par;
    par_data = {<<{v}};
    cyc(4);
    ctl_strobe = 1'b1;
    cyc(4);
    for (int i = 0; i < 8 && !par; i++)
    begin
      sdata = v[i];
      cyc(4);
      sclk = 1'b1;
      cyc(4);
      sclk = 1'b0;
    end
    ctl_strobe = 1'b0;
    cyc(6);
  endtask : wr

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK("pumps idle", 3'b111, {up_n, down_n, lock})
    `CHK("others off", 5'h00, {diag, vco_out, ref_out, pwrdn, cload})
  endtask : t_reset

  // both write paths, bit order seen through bits 3 and 4
  task automatic t_bits;
    for (int m = 0; m < 2; m++)
    begin
      wr(m[0], 5'h01);
      `CHK("power down", 2'b10, {pwrdn, cload})
      wr(m[0], 5'h02);
      `CHK("counter load", 2'b01, {pwrdn, cload})
      wr(m[0], 5'h00);
      `CHK("cleared", 2'b00, {pwrdn, cload})
    end
  endtask : t_bits

  task automatic t_enable_refuse;
    enable_n = 1'b1;
    wr(1'b0, 5'h01);
    `CHK("enable high", 1'b0, pwrdn)
    enable_n = 1'b0;
    cyc(5);
    `CHK("enable low", 1'b1, pwrdn)
    wr(1'b0, 5'h00);
    `CHK("write in power down", 1'b0, pwrdn)
    bmode = 1'b1;
    wr(1'b0, 5'h02);
    `CHK("direct mode refuses", 1'b0, cload)
    bmode = 1'b0;
  endtask : t_enable_refuse

  // bit 5 alone, bit 6 alone, both (modulus select wins)
  task automatic t_diag;
    logic [4:0] code [3] = '{5'h04, 5'h08, 5'h0C};
    for (int k = 0; k < 3; k++)
    begin
      wr(1'b0, code[k]);
      for (int v = 0; v < 2; v++)
      begin
        modulus_select = v[0];
        prescaler_raw = ~v[0];
        cyc(5);
        `CHK("diag source", (k == 1) ? ~v[0] : v[0], diag)
      end
    end
    wr(1'b0, 5'h00);
  endtask : t_diag

  task automatic t_clk_off;
    u_lf.set_lvl(1'b1);
    cyc(5);
    `CHK("clocks pass", 2'b11, {vco_out, ref_out})
    wr(1'b0, 5'h10);
    `CHK("clocks off", 2'b00, {vco_out, ref_out})
    wr(1'b0, 5'h00);
    `CHK("clocks back", 2'b11, {vco_out, ref_out})
    u_lf.set_lvl(1'b0);
    cyc(5);
  endtask : t_clk_off

  // ref first and vco first, short and long offsets, coincident edges
  task automatic t_pfd;
    bit rf [5] = '{1, 0, 1, 0, 1};
    int off [5] = '{5, 7, 1, 12, 0};
    for (int k = 0; k < 5; k++)
    begin
      u_lf.pair(rf[k], off[k]);
      `CHK("up width", rf[k] ? off[k] : 0, up_cnt)
      `CHK("down width", rf[k] ? 0 : off[k], dn_cnt)
      `CHK("lock low", off[k], lk_cnt)
    end
    wr(1'b0, 5'h01);
    u_lf.pair(1'b1, 6);
    `CHK("pumps held", 0, up_cnt + dn_cnt)
    wr(1'b0, 5'h00);
  endtask : t_pfd

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // a full run needs about 1400 cycles
  initial
  begin
    #500000;
    mismatches++;
    test_done();
  end

  initial
  begin
    cyc(12);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_bits();
    t_enable_refuse();
    t_diag();
    t_clk_off();
    t_pfd();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
